// ### rtl/interrupt_vector_mapping.sv
// Contract
// RULE_01 - A source event sets its vector's sticky flag bit.
// RULE_02 - Each source has an enable bit that software writes on or off.
// RULE_03 - A request is raised only while both flag and enable are set.
// RULE_04 - A request holds until its flag is cleared, however slow the core.
// RULE_05 - No maskable request reaches the core without the global enable.
// RULE_06 - Each vector belongs to one source; a peripheral may own several.
// RULE_07 - Reset at vector 0 word 0x00; memory-scan NMI vector 1, ignores enable. Code skips only the global enable; its own enable bit still gates it.
// RULE_08 - Voltage monitor uses vector 2 at word 0x04.
// RULE_09 - RTC count on vector 3, RTC periodic timer on vector 4.
// RULE_10 - Custom logic uses vector 5 at word 0x0A.
// RULE_11 - Vector 7 overflow or low underflow by mode; vector 8 split only.
// RULE_12 - Vectors 9 to 11 carry timer A compares, low compares in split.
// RULE_13 - Timer B captures 0, 1, 2 use vectors 12, 13, 25.
// RULE_14 - Port pin interrupts A, D, C, F use vectors 6, 20, 24, 29.
// RULE_15 - Two-wire target on vector 14, controller on vector 15.
// RULE_16 - Serial peripheral on vector 16, comparator on vector 21.
// RULE_17 - Serial ports 0 and 1 use 17-19 and 26-28: rx, tx empty, tx done.
// RULE_18 - Converter result on vector 22, window compare on vector 23.
// RULE_19 - Nonvolatile memory ready uses vector 30 at word 0x3C.
// RULE_20 - Serial port 2 uses vectors 31 to 33 in the same order.
// RULE_21 - Fetch word address is twice the served vector number.
module interrupt_vector_mapping #(
   parameter int NUM_VEC = ivec_pkg::NUM_VEC
) (
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   input  wire logic               global_irq_enable,
   input  wire logic               timer_a_split_mode,
   input  wire logic               memscan_nonmaskable_irq,
   input  wire logic               voltage_monitor_irq,
   input  wire logic               rtc_count_irq,
   input  wire logic               rtc_periodic_irq,
   input  wire logic               custom_logic_irq,
   input  wire logic               port_a_pin_irq,
   input  wire logic               timer_a_overflow_irq,
   input  wire logic               timer_a_low_underflow_irq,
   input  wire logic               timer_a_high_underflow_irq,
   input  wire logic               timer_a_compare0_irq,
   input  wire logic               timer_a_compare1_irq,
   input  wire logic               timer_a_compare2_irq,
   input  wire logic               timer_a_low_compare0_irq,
   input  wire logic               timer_a_low_compare1_irq,
   input  wire logic               timer_a_low_compare2_irq,
   input  wire logic               timer_b0_capture_irq,
   input  wire logic               timer_b1_capture_irq,
   input  wire logic               timer_b2_capture_irq,
   input  wire logic               two_wire_target_irq,
   input  wire logic               two_wire_controller_irq,
   input  wire logic               serial_periph_irq,
   input  wire logic               serial0_rx_done_irq,
   input  wire logic               serial0_tx_empty_irq,
   input  wire logic               serial0_tx_done_irq,
   input  wire logic               serial1_rx_done_irq,
   input  wire logic               serial1_tx_empty_irq,
   input  wire logic               serial1_tx_done_irq,
   input  wire logic               serial2_rx_done_irq,
   input  wire logic               serial2_tx_empty_irq,
   input  wire logic               serial2_tx_done_irq,
   input  wire logic               port_c_pin_irq,
   input  wire logic               port_d_pin_irq,
   input  wire logic               port_f_pin_irq,
   input  wire logic               comparator_irq,
   input  wire logic               converter_result_irq,
   input  wire logic               converter_window_irq,
   input  wire logic               nvm_ready_irq,
   input  wire logic [NUM_VEC-1:0] enable_wr_en,
   input  wire logic [NUM_VEC-1:0] enable_wr_data,
   input  wire logic [NUM_VEC-1:0] flag_clear,
   output logic      [NUM_VEC-1:0] irq_flag_register,
   output logic      [NUM_VEC-1:0] irq_control_register,
   output logic      [NUM_VEC-1:0] irq_request_q,
   output logic                    irq_valid_q,
   output logic      [5:0]         irq_vector_q,
   output logic      [6:0]         irq_word_addr_q
);

   logic [NUM_VEC-1:0] src_evt;
   logic [NUM_VEC-1:0] flag_q;
   logic [NUM_VEC-1:0] flag_d;
   logic [NUM_VEC-1:0] enable_q;
   logic [NUM_VEC-1:0] request_d;
   logic [2:0]         ta_cmp_evt;
   logic               ta_main_evt;
   logic               ta_high_evt;
   logic [5:0]         serve_vec;

   // Lowest vector number wins; vector 0 is never a request
   function automatic logic [5:0] lowest_req(input logic [NUM_VEC-1:0] req);
      logic [5:0] v;
      v = 6'h00;
      for (int i = NUM_VEC - 1; i > 0; i--) begin
         if (req[i]) begin
            v = 6'(i);
         end
      end
      return v;
   endfunction

   function automatic logic [6:0] word_addr(input logic [5:0] vec);
      return {vec, 1'b0};
   endfunction

   // Timer A shares vectors between modes; the unused mode's events are dropped
   always_comb begin
      if (timer_a_split_mode) begin
         ta_main_evt = timer_a_low_underflow_irq; // RULE_11
         ta_high_evt = timer_a_high_underflow_irq; // RULE_11
         ta_cmp_evt  = {timer_a_low_compare2_irq, timer_a_low_compare1_irq,
                        timer_a_low_compare0_irq}; // RULE_12
      end else begin
         ta_main_evt = timer_a_overflow_irq; // RULE_11
         ta_high_evt = 1'b0; // RULE_11
         ta_cmp_evt  = {timer_a_compare2_irq, timer_a_compare1_irq,
                        timer_a_compare0_irq}; // RULE_12
      end
   end

   // One source per vector, fixed by the package numbering
   always_comb begin
      src_evt = '0; // RULE_06
      src_evt[ivec_pkg::VEC_MEMSCAN_NMI]         = memscan_nonmaskable_irq; // RULE_07
      src_evt[ivec_pkg::VEC_VOLTAGE_MONITOR]     = voltage_monitor_irq; // RULE_08
      src_evt[ivec_pkg::VEC_RTC_COUNT]           = rtc_count_irq; // RULE_09
      src_evt[ivec_pkg::VEC_RTC_PERIODIC]        = rtc_periodic_irq; // RULE_09
      src_evt[ivec_pkg::VEC_CUSTOM_LOGIC]        = custom_logic_irq; // RULE_10
      src_evt[ivec_pkg::VEC_PORT_A_PIN]          = port_a_pin_irq; // RULE_14
      src_evt[ivec_pkg::VEC_TIMER_A_OVF_LUNF]    = ta_main_evt; // RULE_11
      src_evt[ivec_pkg::VEC_TIMER_A_HUNF]        = ta_high_evt; // RULE_11
      for (int c = 0; c < ivec_pkg::TA_CMP_N; c++) begin
         src_evt[int'(ivec_pkg::VEC_TIMER_A_CMP0) + c] = ta_cmp_evt[c]; // RULE_12
      end
      src_evt[ivec_pkg::VEC_TIMER_B0_CAPTURE]    = timer_b0_capture_irq; // RULE_13
      src_evt[ivec_pkg::VEC_TIMER_B1_CAPTURE]    = timer_b1_capture_irq; // RULE_13
      src_evt[ivec_pkg::VEC_TIMER_B2_CAPTURE]    = timer_b2_capture_irq; // RULE_13
      src_evt[ivec_pkg::VEC_TWO_WIRE_TARGET]     = two_wire_target_irq; // RULE_15
      src_evt[ivec_pkg::VEC_TWO_WIRE_CONTROLLER] = two_wire_controller_irq; // RULE_15
      src_evt[ivec_pkg::VEC_SERIAL_PERIPH]       = serial_periph_irq; // RULE_16
      src_evt[ivec_pkg::VEC_COMPARATOR]          = comparator_irq; // RULE_16
      src_evt[ivec_pkg::VEC_PORT_D_PIN]          = port_d_pin_irq; // RULE_14
      src_evt[ivec_pkg::VEC_PORT_C_PIN]          = port_c_pin_irq; // RULE_14
      src_evt[ivec_pkg::VEC_PORT_F_PIN]          = port_f_pin_irq; // RULE_14
      src_evt[ivec_pkg::VEC_CONVERTER_RESULT]    = converter_result_irq; // RULE_18
      src_evt[ivec_pkg::VEC_CONVERTER_WINDOW]    = converter_window_irq; // RULE_18
      src_evt[ivec_pkg::VEC_NVM_READY]           = nvm_ready_irq; // RULE_19
      src_evt[int'(ivec_pkg::VEC_SERIAL0_BASE) + ivec_pkg::SER_RX_DONE]  =
         serial0_rx_done_irq; // RULE_17
      src_evt[int'(ivec_pkg::VEC_SERIAL0_BASE) + ivec_pkg::SER_TX_EMPTY] =
         serial0_tx_empty_irq; // RULE_17
      src_evt[int'(ivec_pkg::VEC_SERIAL0_BASE) + ivec_pkg::SER_TX_DONE]  =
         serial0_tx_done_irq; // RULE_17
      src_evt[int'(ivec_pkg::VEC_SERIAL1_BASE) + ivec_pkg::SER_RX_DONE]  =
         serial1_rx_done_irq; // RULE_17
      src_evt[int'(ivec_pkg::VEC_SERIAL1_BASE) + ivec_pkg::SER_TX_EMPTY] =
         serial1_tx_empty_irq; // RULE_17
      src_evt[int'(ivec_pkg::VEC_SERIAL1_BASE) + ivec_pkg::SER_TX_DONE]  =
         serial1_tx_done_irq; // RULE_17
      src_evt[int'(ivec_pkg::VEC_SERIAL2_BASE) + ivec_pkg::SER_RX_DONE]  =
         serial2_rx_done_irq; // RULE_20
      src_evt[int'(ivec_pkg::VEC_SERIAL2_BASE) + ivec_pkg::SER_TX_EMPTY] =
         serial2_tx_empty_irq; // RULE_20
      src_evt[int'(ivec_pkg::VEC_SERIAL2_BASE) + ivec_pkg::SER_TX_DONE]  =
         serial2_tx_done_irq; // RULE_20
   end

   // An event in the clearing cycle survives: set beats clear
   assign flag_d = (flag_q & ~flag_clear) | src_evt; // RULE_01

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         flag_q <= ivec_pkg::RST_FLAGS;
      end else begin
         flag_q <= flag_d; // RULE_01
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         enable_q <= ivec_pkg::RST_ENABLE;
      end else begin
         enable_q <= (enable_q & ~enable_wr_en) | (enable_wr_data & enable_wr_en); // RULE_02
      end
   end

   // The memory-scan source alone skips the global gate
   assign request_d = flag_q & enable_q & // RULE_03
                      ({NUM_VEC{global_irq_enable}} | ivec_pkg::NMI_MASK); // RULE_05 RULE_07

   // No handshake with the core: a request mirrors flag and enable through the global gate, so it holds
   // as long as software leaves the flag and enable set and the gate open
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_request_q <= '0;
      end else begin
         irq_request_q <= request_d; // RULE_04
      end
   end

   assign serve_vec = lowest_req(irq_request_q);

   // After reset the fetch port shows the reset entry
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_valid_q     <= 1'b0;
         irq_vector_q    <= ivec_pkg::VEC_RESET; // RULE_07
         irq_word_addr_q <= ivec_pkg::RST_ADDR; // RULE_07
      end else begin
         irq_valid_q     <= |irq_request_q;
         irq_vector_q    <= serve_vec;
         irq_word_addr_q <= word_addr(serve_vec); // RULE_21
      end
   end

   assign irq_flag_register    = flag_q;
   assign irq_control_register = enable_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence vmon_armed_s;
      enable_q[ivec_pkg::VEC_VOLTAGE_MONITOR] && global_irq_enable && voltage_monitor_irq;
   endsequence

   sequence vmon_kept_s;
      global_irq_enable && !flag_clear[ivec_pkg::VEC_VOLTAGE_MONITOR]
         && enable_q[ivec_pkg::VEC_VOLTAGE_MONITOR];
   endsequence

   flag_set_a: assert property ( // RULE_01
      (src_evt != '0) |=> ((flag_q & $past(src_evt)) == $past(src_evt)))
      else $error("source event did not set its flag");

   enable_write_a: assert property ( // RULE_02
      (enable_wr_en != '0) |=>
         ((enable_q & $past(enable_wr_en)) == ($past(enable_wr_data) & $past(enable_wr_en))))
      else $error("enable bit write not taken");

   request_cause_a: assert property ( // RULE_03
      (irq_request_q & ~$past(flag_q & enable_q)) == '0)
      else $error("request without flag and enable");

   flag_hold_a: assert property ( // RULE_04
      ($past(flag_q) & ~flag_q & ~$past(flag_clear)) == '0)
      else $error("flag dropped without a clear");

   global_gate_a: assert property ( // RULE_05
      !$past(global_irq_enable) |-> ((irq_request_q & ~ivec_pkg::NMI_MASK) == '0))
      else $error("maskable request with global enable off");

   nmi_bypass_a: assert property ( // RULE_07
      (flag_q[ivec_pkg::VEC_MEMSCAN_NMI] && enable_q[ivec_pkg::VEC_MEMSCAN_NMI])
         |=> irq_request_q[ivec_pkg::VEC_MEMSCAN_NMI])
      else $error("memory scan request not raised");

   vmon_path_a: assert property ( // RULE_08
      vmon_armed_s ##1 vmon_kept_s |=> irq_request_q[ivec_pkg::VEC_VOLTAGE_MONITOR])
      else $error("voltage monitor request missing on vector 2");

   high_unf_normal_a: assert property ( // RULE_11
      (!timer_a_split_mode && !flag_q[ivec_pkg::VEC_TIMER_A_HUNF])
         |=> !flag_q[ivec_pkg::VEC_TIMER_A_HUNF])
      else $error("high underflow flagged in normal mode");

   split_ovf_drop_a: assert property ( // RULE_11
      (timer_a_split_mode && !timer_a_low_underflow_irq
         && !flag_q[ivec_pkg::VEC_TIMER_A_OVF_LUNF])
         |=> !flag_q[ivec_pkg::VEC_TIMER_A_OVF_LUNF])
      else $error("vector 7 set by the wrong mode source");

   fetch_addr_a: assert property ( // RULE_21
      irq_valid_q |-> (irq_word_addr_q == 7'(2 * int'(irq_vector_q))
         && irq_vector_q == $past(serve_vec)))
      else $error("fetch address is not twice the vector");

   // The served number indexes last cycle's requests, not last cycle's number
   serve_lowest_a: assert property ( // RULE_21
      ($past(irq_request_q) != '0) |->
         (irq_valid_q && ((($past(irq_request_q) >> irq_vector_q) & 34'h1) != '0)
          && (($past(irq_request_q) & ((34'h1 << irq_vector_q) - 34'h1)) == '0)))
      else $error("served vector is not the lowest request");

   reset_entry_a: assert property ( // RULE_07
      $past(sys_rst) |-> (flag_q == ivec_pkg::RST_FLAGS && enable_q == ivec_pkg::RST_ENABLE
         && !irq_valid_q && irq_vector_q == ivec_pkg::VEC_RESET
         && irq_word_addr_q == ivec_pkg::RST_ADDR))
      else $error("fetch port not at the reset entry after reset");

   clear_drop_a: assert property ( // RULE_04
      (flag_q & $past(flag_clear & ~src_evt)) == '0)
      else $error("flag survived a clear with no event");

   request_hold_a: assert property ( // RULE_04
      ($past(irq_request_q & flag_q & enable_q) & ~irq_request_q
         & ({NUM_VEC{$past(global_irq_enable)}} | ivec_pkg::NMI_MASK)) == '0)
      else $error("request dropped while flag and enable stood");

   idle_fetch_a: assert property ( // RULE_03
      ($past(irq_request_q) == '0) |-> (!irq_valid_q && irq_vector_q == ivec_pkg::VEC_RESET))
      else $error("fetch port busy with no request");

   sequence nmi_event_s;
      memscan_nonmaskable_irq ##1 enable_q[ivec_pkg::VEC_MEMSCAN_NMI];
   endsequence

   sequence nmi_served_s;
      irq_request_q[ivec_pkg::VEC_MEMSCAN_NMI] ##1
         (irq_valid_q && irq_vector_q == ivec_pkg::VEC_MEMSCAN_NMI);
   endsequence

   // Global enable plays no part: the scan source must get through with it off
   nmi_path_a: assert property ( // RULE_07
      nmi_event_s |=> nmi_served_s)
      else $error("memory scan request not served on vector 1");

endmodule

// ### rtl/ivec_pkg.sv
package ivec_pkg;
   localparam int NUM_VEC  = 34;
   localparam int VEC_W    = 6;
   localparam int ADDR_W   = 7;
   localparam int TA_CMP_N = 3;

   // Vector numbers; the word address of vector n is always 2*n
   localparam logic [VEC_W-1:0] VEC_RESET               = 6'h00;
   localparam logic [VEC_W-1:0] VEC_MEMSCAN_NMI         = 6'h01;
   localparam logic [VEC_W-1:0] VEC_VOLTAGE_MONITOR     = 6'h02;
   localparam logic [VEC_W-1:0] VEC_RTC_COUNT           = 6'h03;
   localparam logic [VEC_W-1:0] VEC_RTC_PERIODIC        = 6'h04;
   localparam logic [VEC_W-1:0] VEC_CUSTOM_LOGIC        = 6'h05;
   localparam logic [VEC_W-1:0] VEC_PORT_A_PIN          = 6'h06;
   localparam logic [VEC_W-1:0] VEC_TIMER_A_OVF_LUNF    = 6'h07;
   localparam logic [VEC_W-1:0] VEC_TIMER_A_HUNF        = 6'h08;
   localparam logic [VEC_W-1:0] VEC_TIMER_A_CMP0        = 6'h09;
   localparam logic [VEC_W-1:0] VEC_TIMER_B0_CAPTURE    = 6'h0C;
   localparam logic [VEC_W-1:0] VEC_TIMER_B1_CAPTURE    = 6'h0D;
   localparam logic [VEC_W-1:0] VEC_TWO_WIRE_TARGET     = 6'h0E;
   localparam logic [VEC_W-1:0] VEC_TWO_WIRE_CONTROLLER = 6'h0F;
   localparam logic [VEC_W-1:0] VEC_SERIAL_PERIPH       = 6'h10;
   localparam logic [VEC_W-1:0] VEC_SERIAL0_BASE        = 6'h11;
   localparam logic [VEC_W-1:0] VEC_PORT_D_PIN          = 6'h14;
   localparam logic [VEC_W-1:0] VEC_COMPARATOR          = 6'h15;
   localparam logic [VEC_W-1:0] VEC_CONVERTER_RESULT    = 6'h16;
   localparam logic [VEC_W-1:0] VEC_CONVERTER_WINDOW    = 6'h17;
   localparam logic [VEC_W-1:0] VEC_PORT_C_PIN          = 6'h18;
   localparam logic [VEC_W-1:0] VEC_TIMER_B2_CAPTURE    = 6'h19;
   localparam logic [VEC_W-1:0] VEC_SERIAL1_BASE        = 6'h1A;
   localparam logic [VEC_W-1:0] VEC_PORT_F_PIN          = 6'h1D;
   localparam logic [VEC_W-1:0] VEC_NVM_READY           = 6'h1E;
   localparam logic [VEC_W-1:0] VEC_SERIAL2_BASE        = 6'h1F;

   // Offsets inside a serial port triple
   localparam int SER_RX_DONE  = 0;
   localparam int SER_TX_EMPTY = 1;
   localparam int SER_TX_DONE  = 2;

   localparam logic [NUM_VEC-1:0] RST_FLAGS  = 34'h0_0000_0000;
   localparam logic [NUM_VEC-1:0] RST_ENABLE = 34'h0_0000_0000;
   // Sources that bypass the global enable
   localparam logic [NUM_VEC-1:0] NMI_MASK   = 34'h0_0000_0002;
   localparam logic [ADDR_W-1:0]  RST_ADDR   = 7'h00;
endpackage

// ### testbench/core_model.sv
module core_model (
   input  wire logic                          clk_sys,
   input  wire logic                          sys_rst,
   input  wire logic                          core_on,
   input  wire logic [3:0]                    lat,
   input  wire logic                          irq_valid_q,
   input  wire logic [5:0]                    irq_vector_q,
   output logic      [ivec_pkg::NUM_VEC-1:0]  core_clear
);
   timeunit 1ns;
   timeprecision 1ns;
   int                           cnt;
   logic [ivec_pkg::NUM_VEC-1:0] hit;
   // Holds off after a clear: valid only drops two edges after the flag clears.
   // The bound is a floor, not a match, so a latency change mid-count cannot stall it
   always @(posedge clk_sys) begin
      hit = '0;
      if (sys_rst || !irq_valid_q || !core_on || cnt >= lat + 4) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
         if (cnt == lat) begin
            hit[irq_vector_q] = 1'b1;
         end
      end
      core_clear <= #1 hit;
   end
endmodule

// ### testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int N = ivec_pkg::NUM_VEC;
   logic         clk_sys, sys_rst, gie, split, core_on, valid, valid_m, armed;
   logic [3:0]   lat;
   logic [37:0]  ev;
   logic [N-1:0] wr_en, wr_data, tb_clear, core_clear, flags, ctrl, req, flag_m, en_m, req_m;
   logic [5:0]   vec, vec_m;
   logic [6:0]   addr;
   int           n_fail, cmp_count, cycles, e;

`define CHECK(nm, xp, got) begin cmp_count++; if ((got) !== (xp)) begin n_fail++; \
   $display("MISMATCH %s exp %0h got %0h", nm, xp, got); end end

   interrupt_vector_mapping u_interrupt_vector_mapping (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .global_irq_enable(gie),
      .timer_a_split_mode(split), .memscan_nonmaskable_irq(ev[1]),
      .voltage_monitor_irq(ev[2]), .rtc_count_irq(ev[3]), .rtc_periodic_irq(ev[4]),
      .custom_logic_irq(ev[5]), .port_a_pin_irq(ev[6]), .timer_a_overflow_irq(ev[7]),
      .timer_a_low_underflow_irq(ev[34]), .timer_a_high_underflow_irq(ev[8]),
      .timer_a_compare0_irq(ev[9]), .timer_a_compare1_irq(ev[10]),
      .timer_a_compare2_irq(ev[11]), .timer_a_low_compare0_irq(ev[35]),
      .timer_a_low_compare1_irq(ev[36]), .timer_a_low_compare2_irq(ev[37]),
      .timer_b0_capture_irq(ev[12]), .timer_b1_capture_irq(ev[13]),
      .timer_b2_capture_irq(ev[25]), .two_wire_target_irq(ev[14]),
      .two_wire_controller_irq(ev[15]), .serial_periph_irq(ev[16]),
      .serial0_rx_done_irq(ev[17]), .serial0_tx_empty_irq(ev[18]),
      .serial0_tx_done_irq(ev[19]), .serial1_rx_done_irq(ev[26]),
      .serial1_tx_empty_irq(ev[27]), .serial1_tx_done_irq(ev[28]),
      .serial2_rx_done_irq(ev[31]), .serial2_tx_empty_irq(ev[32]),
      .serial2_tx_done_irq(ev[33]), .port_c_pin_irq(ev[24]), .port_d_pin_irq(ev[20]),
      .port_f_pin_irq(ev[29]), .comparator_irq(ev[21]), .converter_result_irq(ev[22]),
      .converter_window_irq(ev[23]), .nvm_ready_irq(ev[30]), .enable_wr_en(wr_en),
      .enable_wr_data(wr_data), .flag_clear(tb_clear | core_clear),
      .irq_flag_register(flags), .irq_control_register(ctrl), .irq_request_q(req),
      .irq_valid_q(valid), .irq_vector_q(vec), .irq_word_addr_q(addr));

   core_model u_core_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .core_on(core_on),
      .lat(lat), .irq_valid_q(valid), .irq_vector_q(vec), .core_clear(core_clear));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Ports are wired so that event bit k feeds vector k; timer A split events sit at 34..37
   function automatic logic [N-1:0] set_of(logic [37:0] x, logic s);
      logic [N-1:0] v;
      v = x[N-1:0];
      v[0] = 1'b0;
      if (s) begin
         v[7] = x[34];
         v[11:9] = x[37:35];
      end else begin
         v[8] = 1'b0;
      end
      return v;
   endfunction

   function automatic int exp_vec(int k, logic s);
      if (k >= 34) return s ? (k == 34 ? 7 : k - 26) : -1;
      if (k == 8) return s ? 8 : -1;
      if (k == 7 || (k >= 9 && k <= 11)) return s ? -1 : k;
      return k;
   endfunction

   function automatic int lowest(logic [N-1:0] r);
      for (int n = 0; n < N; n++) if (r[n]) return n;
      return 0;
   endfunction

   always @(posedge clk_sys) begin
      armed <= 1'b1;
      cycles++;
      if (sys_rst) begin
         {flag_m, en_m, req_m, valid_m, vec_m} <= '0;
      end else begin
         flag_m <= set_of(ev, split) | (flag_m & ~(tb_clear | core_clear));
         en_m <= (en_m & ~wr_en) | (wr_data & wr_en);
         req_m <= flag_m & en_m & {{N-2{gie}}, 1'b1, gie};
         valid_m <= |req_m;
         vec_m <= 6'(lowest(req_m));
      end
      if (cycles > 12000) begin
         n_fail++;
         test_done();
      end
   end

   always @(negedge clk_sys) if (armed) begin
      `CHECK("flags", flag_m, flags)
      `CHECK("enables", en_m, ctrl)
      `CHECK("requests", req_m, req)
      `CHECK("valid", valid_m, valid)
      `CHECK("vector", vec_m, vec)
      `CHECK("address", {vec_m, 1'b0}, addr)
   end

   task automatic step(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic test_done();
      if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      {sys_rst, gie, split, core_on, ev, wr_en, wr_data, tb_clear} = '0;
      {armed, n_fail, cmp_count, cycles, lat} = '0;
      sys_rst = 1'b1;
      void'($urandom(32'hAF55F3B5));
      step(10);
      sys_rst = 1'b0;
      {wr_en, wr_data, gie, core_on} = '1;
      step(1);
      wr_en = '0;
      // Every source alone in both timer modes, inactive-mode events included
      for (int s = 0; s < 2; s++) begin
         split = s[0];
         for (int k = 1; k < 38; k++) begin
            ev = 38'(1) << k;
            step(1);
            ev = '0;
            step(2);
            e = exp_vec(k, split);
            `CHECK("served valid", logic'(e >= 0), valid)
            if (e >= 0) begin
               `CHECK("served vec", 6'(e), vec)
               `CHECK("served addr", {6'(e), 1'b0}, addr)
            end
            step(10);
         end
      end
      // Global enable off: only the memory-scan source may get through
      gie = 1'b0;
      ev[2] = 1'b1;
      step(1);
      ev = '0;
      step(6);
      `CHECK("masked", 1'b0, valid)
      ev[1] = 1'b1;
      step(1);
      ev = '0;
      step(2);
      `CHECK("nmi", 6'h01, vec)
      step(8);
      core_on = 1'b0;
      gie = 1'b1;
      step(60);
      `CHECK("held", 6'h02, vec)
      core_on = 1'b1;
      lat = 4'd7;
      step(20);
      for (int i = 0; i < 3000; i++) begin
         ev = ($urandom % 4 == 0) ? 38'(1) << ($urandom % 38) : '0;
         tb_clear = ($urandom % 8 == 0) ? 34'(1) << ($urandom % N) : '0;
         wr_en = ($urandom % 16 == 0) ? N'({$urandom, $urandom}) : '0;
         wr_data = N'({$urandom, $urandom});
         if ($urandom % 64 == 0) gie = ~gie;
         if ($urandom % 256 == 0) split = ~split;
         if ($urandom % 32 == 0) core_on = ~core_on;
         lat = 4'($urandom % 8);
         sys_rst = (i >= 1500 && i < 1503);
         step(1);
      end
      test_done();
   end
endmodule
